// ### verilog/tti_regs.svh
// Register offsets, field positions, reset values and timing counts of the transfer unit
`ifndef TTI_REGS_SVH
`define TTI_REGS_SVH

`define TTI_OFS_CTRL 8'h00
`define TTI_OFS_CMD 8'h04
`define TTI_OFS_XA 8'h08
`define TTI_OFS_DE 8'h0C
`define TTI_OFS_HL 8'h10
`define TTI_OFS_PC 8'h14
`define TTI_OFS_STAT 8'h18
`define TTI_OFS_ROM 8'h1C
`define TTI_OFS_RAM 8'h20

`define TTI_CTRL_CLKDIV_LSB 0
`define TTI_CTRL_SUBCLK_BIT 2
`define TTI_CTRL_BANKEN_BIT 3
`define TTI_CTRL_BANKSEL_LSB 4
`define TTI_CTRL_RESET 8'h00

`define TTI_CMD_OP_LSB 0
`define TTI_CMD_NLEN_LSB 4
`define TTI_CMD_NTC_BIT 6

`define TTI_ROM_DATA_LSB 16
`define TTI_RAM_DATA_LSB 16

`define TTI_CLK_PERIOD_NS 10
`define TTI_SHIFT_SUB 3'h5
`define TTI_CYC_HL_STEP 3'h2
`define TTI_CYC_TABLE 3'h3
`define TTI_CYC_WORD 3'h2
`define TTI_CYC_SINGLE 3'h1
`define TTI_SKIP_SHORT 3'h1
`define TTI_SKIP_LONG 3'h2
`define TTI_LONG_INSN_LEN 2'h3

`endif

// ### verilog/tti_pkg.sv
// Types shared by the transfer unit files
package tti_pkg;

   typedef enum logic [3:0] {
      OP_MOV_HLI = 4'h0,
      OP_MOV_HLD = 4'h1,
      OP_EXCH_HLI = 4'h2,
      OP_EXCH_HLD = 4'h3,
      OP_MOV_DE = 4'h4,
      OP_MOV_DL = 4'h5,
      OP_EXCH_DE = 4'h6,
      OP_EXCH_DL = 4'h7,
      OP_TBL_DE = 4'h8,
      OP_TBL_XA = 4'h9,
      OP_LDW_HL = 4'hA,
      OP_STW_HL = 4'hB,
      OP_SKIP = 4'hC,
      OP_NOP = 4'hF
   } tti_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_ACCESS = 2'b10,
      ST_WAIT = 2'b11
   } tti_state_e;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } tti_aphase_s;

   typedef struct packed {
      tti_op_e op;
      logic [1:0] next_len;
      logic next_tcall;
   } tti_cmd_s;

endpackage

// ### verilog/tti_mem.sv
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
module tti_mem #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   input wire logic hclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // No reset on the array: contents are loaded by software
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge hclk) begin
      rdata <= mem[raddr];
   end
endmodule

// ### verilog/tti_core.sv
// Transfer and table-read execution unit with AHB-Lite register access
//
// Behaviour
// - skipped 1/2-byte instruction costs one cycle
// - skipped 3-byte instruction costs two cycles
// - skipped table call always costs one cycle
// - machine cycle equals selected CPU clock period
// - DE table read loads XA, three cycles
// - XA table read uses old XA, three cycles
// - DE and DL accesses always use bank 0
// - eight-bit data accesses use even addresses only
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tti_regs.svh"
module tti_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   tti_pkg::tti_aphase_s aph_q;
   tti_pkg::tti_cmd_s cmd_q;
   tti_pkg::tti_state_e state_q;
   logic [7:0] ctrl_q;
   logic [7:0] xa_q;
   logic [7:0] de_q;
   logic [7:0] hl_q;
   logic [13:0] pc_q;
   logic [7:0] ticks_q;
   logic [7:0] total_q;
   logic [2:0] mcyc_q;
   logic skip_q;
   logic align_err_q;
   logic [3:0] bank_q;
   logic [31:0] hrdata_q;
   logic [11:0] dadr;
   logic [13:0] radr;
   logic [7:0] rom_rdata;
   logic [7:0] ram_rdata;
   logic ram_we;
   logic [10:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic [3:0] nib_rd;
   logic [7:0] l_next;
   logic skip_now;
   logic [2:0] mcyc_now;
   logic wr_en;
   logic busy;

   // Five CPU clock periods: sub clock, or main clock divided by 8, 4, 2, 1
   function automatic logic [2:0] clk_shift(input logic [1:0] clk_div, input logic sub_clk);
      if (sub_clk) begin
         return `TTI_SHIFT_SUB;
      end
      return 3'h3 - {1'b0, clk_div};
   endfunction

   function automatic logic [2:0] skip_cost(input logic skip, input logic [1:0] nlen,
                                            input logic ntc);
      if (!skip) begin
         return 3'h0;
      end
      if (ntc) begin
         return `TTI_SKIP_SHORT;
      end
      if (nlen == `TTI_LONG_INSN_LEN) begin
         return `TTI_SKIP_LONG;
      end
      return `TTI_SKIP_SHORT;
   endfunction

   function automatic logic [2:0] base_cycles(input tti_pkg::tti_op_e op);
      case (op)
         tti_pkg::OP_MOV_HLI, tti_pkg::OP_MOV_HLD,
         tti_pkg::OP_EXCH_HLI, tti_pkg::OP_EXCH_HLD: begin
            return `TTI_CYC_HL_STEP;
         end
         tti_pkg::OP_TBL_DE, tti_pkg::OP_TBL_XA: begin
            return `TTI_CYC_TABLE;
         end
         tti_pkg::OP_LDW_HL, tti_pkg::OP_STW_HL: begin
            return `TTI_CYC_WORD;
         end
         default: begin
            return `TTI_CYC_SINGLE;
         end
      endcase
   endfunction

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign busy = (state_q != tti_pkg::ST_IDLE);
   assign wr_en = aph_q.valid && aph_q.write;

   // Data memory address and program memory address from the latched command
   always_comb begin
      dadr = {4'h0, hl_q};
      radr = {pc_q[13:8], de_q};
      case (cmd_q.op)
         tti_pkg::OP_MOV_DE, tti_pkg::OP_EXCH_DE: begin
            dadr = {4'h0, de_q};
         end
         tti_pkg::OP_MOV_DL, tti_pkg::OP_EXCH_DL: begin
            dadr = {4'h0, de_q[7:4], hl_q[3:0]};
         end
         tti_pkg::OP_LDW_HL, tti_pkg::OP_STW_HL: begin
            // Pair access forced onto an even nibble; odd HL is flagged
            dadr = {(ctrl_q[`TTI_CTRL_BANKEN_BIT] ? ctrl_q[`TTI_CTRL_BANKSEL_LSB +: 4] : 4'h0),
                    hl_q[7:1], 1'b0};
         end
         default: begin
            dadr = {(ctrl_q[`TTI_CTRL_BANKEN_BIT] ? ctrl_q[`TTI_CTRL_BANKSEL_LSB +: 4] : 4'h0),
                    hl_q};
         end
      endcase
      if (cmd_q.op == tti_pkg::OP_TBL_XA) begin
         radr = {pc_q[13:8], xa_q};
      end
   end

   assign nib_rd = dadr[0] ? ram_rdata[7:4] : ram_rdata[3:0];

   always_comb begin
      l_next = hl_q;
      skip_now = 1'b0;
      case (cmd_q.op)
         tti_pkg::OP_MOV_HLI, tti_pkg::OP_EXCH_HLI: begin
            l_next = {hl_q[7:4], hl_q[3:0] + 4'h1};
            skip_now = (l_next[3:0] == 4'h0);
         end
         tti_pkg::OP_MOV_HLD, tti_pkg::OP_EXCH_HLD: begin
            l_next = {hl_q[7:4], hl_q[3:0] - 4'h1};
            skip_now = (l_next[3:0] == 4'hF);
         end
         tti_pkg::OP_SKIP: begin
            skip_now = 1'b1;
         end
         default: begin
            skip_now = 1'b0;
         end
      endcase
      mcyc_now = base_cycles(cmd_q.op) + skip_cost(skip_now, cmd_q.next_len, cmd_q.next_tcall);
   end

   // Bus writes to the data memory only while idle; the core owns it otherwise
   always_comb begin
      ram_we = 1'b0;
      ram_waddr = dadr[11:1];
      ram_wdata = ram_rdata;
      if (state_q == tti_pkg::ST_ACCESS) begin
         case (cmd_q.op)
            tti_pkg::OP_EXCH_HLI, tti_pkg::OP_EXCH_HLD,
            tti_pkg::OP_EXCH_DE, tti_pkg::OP_EXCH_DL: begin
               ram_we = 1'b1;
               ram_wdata = dadr[0] ? {xa_q[3:0], ram_rdata[3:0]} :
                                     {ram_rdata[7:4], xa_q[3:0]};
            end
            tti_pkg::OP_STW_HL: begin
               ram_we = 1'b1;
               ram_wdata = xa_q;
            end
            default: begin
               ram_we = 1'b0;
            end
         endcase
      end else if (!busy && wr_en && aph_q.addr == `TTI_OFS_RAM) begin
         ram_we = 1'b1;
         ram_waddr = hwdata[10:0];
         ram_wdata = hwdata[`TTI_RAM_DATA_LSB +: 8];
      end
   end

   tti_mem #(.AW(14), .DW(8)) u_rom (
      .hclk(hclk),
      .we(wr_en && aph_q.addr == `TTI_OFS_ROM && !busy),
      .waddr(hwdata[13:0]),
      .wdata(hwdata[`TTI_ROM_DATA_LSB +: 8]),
      .raddr(radr),
      .rdata(rom_rdata)
   );

   tti_mem #(.AW(11), .DW(8)) u_ram (
      .hclk(hclk),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr(dadr[11:1]),
      .rdata(ram_rdata)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_q <= '0;
      end else if (hready) begin
         aph_q.valid <= hsel && htrans[1];
         aph_q.write <= hwrite;
         aph_q.addr <= haddr[7:0];
      end
   end

   // Read data registered in the address phase so it stands through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            `TTI_OFS_CTRL: hrdata_q <= {24'h000000, ctrl_q};
            // Read back in the same layout as the command write
            `TTI_OFS_CMD: hrdata_q <= {25'h0, cmd_q.next_tcall, cmd_q.next_len, cmd_q.op};
            `TTI_OFS_XA: hrdata_q <= {24'h000000, xa_q};
            `TTI_OFS_DE: hrdata_q <= {24'h000000, de_q};
            `TTI_OFS_HL: hrdata_q <= {24'h000000, hl_q};
            `TTI_OFS_PC: hrdata_q <= {18'h0, pc_q};
            `TTI_OFS_STAT: hrdata_q <= {14'h0, total_q, bank_q, mcyc_q,
                                        align_err_q, skip_q, busy};
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `TTI_CTRL_RESET;
         pc_q <= 14'h0000;
      end else if (wr_en && !busy) begin
         if (aph_q.addr == `TTI_OFS_CTRL) begin
            ctrl_q <= hwdata[7:0];
         end
         if (aph_q.addr == `TTI_OFS_PC) begin
            pc_q <= hwdata[13:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= tti_pkg::ST_IDLE;
         cmd_q <= '{op: tti_pkg::OP_NOP, next_len: 2'h1, next_tcall: 1'b0};
         ticks_q <= 8'h00;
      end else begin
         ticks_q <= ticks_q + 8'h01;
         case (state_q)
            tti_pkg::ST_IDLE: begin
               ticks_q <= 8'h00;
               if (wr_en && aph_q.addr == `TTI_OFS_CMD) begin
                  cmd_q <= '{op: tti_pkg::tti_op_e'(hwdata[`TTI_CMD_OP_LSB +: 4]),
                             next_len: hwdata[`TTI_CMD_NLEN_LSB +: 2],
                             next_tcall: hwdata[`TTI_CMD_NTC_BIT]};
                  state_q <= tti_pkg::ST_ISSUE;
               end
            end
            tti_pkg::ST_ISSUE: state_q <= tti_pkg::ST_ACCESS;
            tti_pkg::ST_ACCESS: state_q <= tti_pkg::ST_WAIT;
            tti_pkg::ST_WAIT: begin
               // Memory latency gives a floor of three clocks per command
               if (ticks_q + 8'h01 >= total_q) begin
                  state_q <= tti_pkg::ST_IDLE;
               end
            end
            default: state_q <= tti_pkg::ST_IDLE;
         endcase
      end
   end

   // Working registers: bus loads them while idle, the core updates XA and HL in the access cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xa_q <= 8'h00;
         de_q <= 8'h00;
         hl_q <= 8'h00;
      end else if (state_q == tti_pkg::ST_ACCESS) begin
         hl_q <= l_next;
         case (cmd_q.op)
            tti_pkg::OP_TBL_DE, tti_pkg::OP_TBL_XA: begin
               xa_q <= rom_rdata;
            end
            tti_pkg::OP_LDW_HL: xa_q <= ram_rdata;
            tti_pkg::OP_MOV_HLI, tti_pkg::OP_MOV_HLD, tti_pkg::OP_MOV_DE,
            tti_pkg::OP_MOV_DL, tti_pkg::OP_EXCH_HLI, tti_pkg::OP_EXCH_HLD,
            tti_pkg::OP_EXCH_DE, tti_pkg::OP_EXCH_DL: begin
               xa_q <= {xa_q[7:4], nib_rd};
            end
            default: xa_q <= xa_q;
         endcase
      end else if (wr_en && !busy) begin
         if (aph_q.addr == `TTI_OFS_XA) begin
            xa_q <= hwdata[7:0];
         end
         if (aph_q.addr == `TTI_OFS_DE) begin
            de_q <= hwdata[7:0];
         end
         if (aph_q.addr == `TTI_OFS_HL) begin
            hl_q <= hwdata[7:0];
         end
      end
   end

   // Result of the last command; total counts clocks of CPU-clock-length machine cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         total_q <= 8'h00;
         mcyc_q <= 3'h0;
         skip_q <= 1'b0;
         align_err_q <= 1'b0;
         bank_q <= 4'h0;
      end else if (state_q == tti_pkg::ST_ACCESS) begin
         mcyc_q <= mcyc_now;
         total_q <= 8'({5'h00, mcyc_now} << clk_shift(ctrl_q[`TTI_CTRL_CLKDIV_LSB +: 2],
            ctrl_q[`TTI_CTRL_SUBCLK_BIT]));
         skip_q <= skip_now;
         bank_q <= dadr[11:8];
         align_err_q <= (cmd_q.op == tti_pkg::OP_LDW_HL || cmd_q.op == tti_pkg::OP_STW_HL)
                        && hl_q[0];
      end
   end
endmodule

// ### tb/tti_core_properties.sv
// Timing checks of the transfer unit, judged through its status register
`timescale 1ns/1ps
module tti_core_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   logic [7:0] a_q;
   logic w_q;
   logic r_q;
   logic [2:0] ctl_q;
   logic [7:0] hl_q;
   logic [6:0] cmd_q;
   logic [3:0] lc_q;
   logic [7:0] mc_q;
   logic [7:0] mult;
   logic [7:0] cyc;
   logic [7:0] sc;
   logic done;
   // Divider and L latched per command, so later writes cannot skew a check
   assign mult = ctl_q[2] ? 8'h20 : (8'h08 >> ctl_q[1:0]);
   assign cyc = {5'h00, hrdata[5:3]};
   assign sc = (cmd_q[5:4] == 2'h3 && !cmd_q[6]) ? 8'h02 : 8'h01;
   assign done = r_q && a_q == 8'h18 && !hrdata[0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_q <= 8'h00;
         w_q <= 1'b0;
         r_q <= 1'b0;
         ctl_q <= 3'h0;
         hl_q <= 8'h00;
         cmd_q <= 7'h0F;
         lc_q <= 4'h0;
         mc_q <= 8'h08;
      end else begin
         w_q <= hsel && htrans[1] && hready && hwrite;
         r_q <= hsel && htrans[1] && hready && !hwrite;
         if (hsel && htrans[1] && hready) a_q <= haddr[7:0];
         if (w_q && a_q == 8'h00) ctl_q <= hwdata[2:0];
         if (w_q && a_q == 8'h10) hl_q <= hwdata[7:0];
         if (w_q && a_q == 8'h04) begin
            cmd_q <= hwdata[6:0];
            lc_q <= hl_q[3:0];
            mc_q <= mult;
         end
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   clk_period_a: assert property (
      done && cyc * mc_q >= 8'h03 |-> hrdata[17:10] == cyc * mc_q)
      else $error("total clocks differ from cycles times divider");
   short_skip_a: assert property (
      done && cmd_q[3:0] == 4'hC && !cmd_q[6] && cmd_q[5:4] != 2'h3 |-> cyc == 8'h02)
      else $error("short skip cost wrong");
   long_skip_a: assert property (
      done && cmd_q[3:0] == 4'hC && !cmd_q[6] && cmd_q[5:4] == 2'h3 |-> cyc == 8'h03)
      else $error("long skip cost wrong");
   tcall_skip_a: assert property (
      done && cmd_q[3:0] == 4'hC && cmd_q[6] |-> cyc == 8'h02 && hrdata[1])
      else $error("table call skip cost wrong");
   table_cyc_a: assert property (
      done && cmd_q[3:1] == 3'b100 |-> cyc == 8'h03 && !hrdata[1])
      else $error("table read cycles wrong");
   hl_step_a: assert property (
      done && cmd_q[3:2] == 2'b00 |-> cyc == (hrdata[1] ? 8'h02 + sc : 8'h02))
      else $error("step move cycles wrong");
   hl_wrap_a: assert property (
      done && cmd_q[3:2] == 2'b00 |-> hrdata[1] == (cmd_q[0] ? lc_q == 4'h0 : lc_q == 4'hF))
      else $error("step move skip wrong");
   bank_zero_a: assert property (
      done && cmd_q[3:2] == 2'b01 |-> hrdata[9:6] == 4'h0 && cyc == 8'h01)
      else $error("pointer access left bank zero");
   pair_even_a: assert property (
      done && cmd_q[3:1] == 3'b101 |-> hrdata[2] == lc_q[0] && cyc == 8'h02)
      else $error("odd pair address not flagged");
endmodule
bind tti_core tti_core_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// ### tb/transfer_instruction_timing_bench.sv
// Register-driven bench for the transfer unit
`timescale 1ns/1ps
module transfer_instruction_timing_bench;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic hready;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] st;
   logic [6:0] sk [4] = '{7'h1C, 7'h2C, 7'h3C, 7'h7C};
   int n_errors = 0;
   int n_tests = 0;
   int np = 0;
   assign hready = hreadyout;
   tti_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   task automatic complete_run;
      if (n_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      st = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(st, e);
   endtask
   // Busy is polled under a bound; a hang shows up as a failed check
   task automatic run(input logic [6:0] c);
      int k;
      wr(8'h04, {25'h0, c});
      k = 0;
      st = 32'h1;
      while (st[0] !== 1'b0 && k < 200) begin
         xfer(8'h18, 1'b0, 32'h0);
         k++;
      end
      np = k;
      chk({31'h0, st[0]}, 32'h0);
   endtask
   task automatic sc(input logic [2:0] c, input logic s, input logic [7:0] t);
      chk({20'h0, st[17:10], st[5:3], st[1]}, {20'h0, t, c, s});
   endtask
   task automatic hl(input logic [7:0] h, input logic [6:0] c, input logic [7:0] nh,
      input logic [7:0] xa, input logic [2:0] cy, input logic s);
      wr(8'h10, {24'h0, h});
      run(c);
      sc(cy, s, {2'h0, cy, 3'h0});
      rc(8'h10, {24'h0, nh});
      rc(8'h08, {24'h0, xa});
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      complete_run;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(8'h00, 32'h0);
      rc(8'h40, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, (i < 4) ? 32'(i) : 32'h4);
         run(7'h3C);
         sc(3'h3, 1'b1, (i < 4) ? (8'h18 >> i) : 8'h60);
         // Busy spans the total clock count; one poll per two clocks
         chk(np, (((i < 4) ? (24 >> i) : 96) + 1) / 2 + 1);
      end
      wr(8'h00, 32'h0);
      foreach (sk[i]) begin
         run(sk[i]);
         sc((sk[i] == 7'h3C) ? 3'h3 : 3'h2, 1'b1, (sk[i] == 7'h3C) ? 8'h18 : 8'h10);
      end
      wr(8'h14, 32'h2A55);
      wr(8'h0C, 32'h3C);
      wr(8'h1C, 32'hA72A3C);
      wr(8'h1C, 32'h912A5E);
      wr(8'h1C, 32'h4B2A91);
      run(7'h18);
      sc(3'h3, 1'b0, 8'h18);
      rc(8'h08, 32'hA7);
      wr(8'h08, 32'h5E);
      run(7'h19);
      rc(8'h08, 32'h91);
      run(7'h19);
      rc(8'h08, 32'h4B);
      wr(8'h08, 32'h50);
      wr(8'h20, 32'hC00017);
      wr(8'h20, 32'h0D0010);
      wr(8'h20, 32'h060012);
      hl(8'h2F, 7'h10, 8'h20, 8'h5C, 3'h3, 1'b1);
      hl(8'h20, 7'h31, 8'h2F, 8'h5D, 3'h4, 1'b1);
      hl(8'h24, 7'h12, 8'h25, 8'h56, 3'h2, 1'b0);
      wr(8'h00, 32'h18);
      wr(8'h20, 32'h070023);
      wr(8'h20, 32'h0900A3);
      wr(8'h0C, 32'h46);
      run(7'h14);
      chk({28'h0, st[9:6]}, 32'h0);
      rc(8'h08, 32'h57);
      wr(8'h10, 32'h06);
      wr(8'h08, 32'h50);
      run(7'h15);
      rc(8'h08, 32'h57);
      wr(8'h00, 32'h0);
      wr(8'h10, 32'h2F);
      run(7'h1A);
      chk({28'h0, st[5:3], st[2]}, 32'h5);
      rc(8'h08, 32'hC0);
      wr(8'h10, 32'h30);
      run(7'h1B);
      chk({28'h0, st[5:3], st[2]}, 32'h4);
      wr(8'h08, 32'h0);
      wr(8'h10, 32'h31);
      run(7'h1A);
      rc(8'h08, 32'hC0);
      wr(8'h0C, 32'h24);
      run(7'h14);
      rc(8'h08, 32'hCD);
      hl(8'h2F, 7'h23, 8'h2E, 8'hCC, 3'h2, 1'b0);
      wr(8'h00, 32'h18);
      run(7'h17);
      rc(8'h08, 32'hC0);
      run(7'h16);
      rc(8'h08, 32'hCD);
      wr(8'h00, 32'h0);
      wr(8'h10, 32'h2E);
      run(7'h1A);
      rc(8'h08, 32'hDC);
      run(7'h1F);
      sc(3'h1, 1'b0, 8'h08);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(8'h04, 32'h1F);
      rc(8'h08, 32'h0);
      rc(8'h18, 32'h0);
      complete_run;
   end
endmodule
